// ==== core/bsac_cfg.svh ====
// constants for the bus snoop and arbitration control block
`ifndef BSAC_CFG_SVH
`define BSAC_CFG_SVH

// snoop control encodings
`define BSAC_SNP_NONE     2'h0
`define BSAC_SNP_UPDATE   2'h1
`define BSAC_SNP_INVAL    2'h2
`define BSAC_SNP_RSVD     2'h3

// synchroniser depth for pin inputs
`define BSAC_SYNC_STAGES  2

// values held by control state after rst_n
`define BSAC_RST_HOLD_OFF 1'h1
`define BSAC_RST_BUS_MODE 1'h1
`define BSAC_RST_DRIVE    3'h0
`define BSAC_RST_CACHE_ON 1'h1

`endif

// ==== core/bsac_pkg.sv ====
// types shared by the bus snoop and arbitration control block
package bsac_pkg;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_REQ  = 2'b01,
    ARB_OWN  = 2'b10,
    ARB_REL  = 2'b11
  } bsac_arb_t;

  typedef enum logic [1:0] {
    SNP_IDLE = 2'b00,
    SNP_LOOK = 2'b01,
    SNP_MEM  = 2'b10,
    SNP_INTV = 2'b11
  } bsac_snp_t;

  // pin inputs, all asserted high except irq_level_n
  typedef struct packed {
    logic       hard_reset_in;
    logic       xfer_start;
    logic       xfer_ack;
    logic       xfer_err_ack;
    logic       auto_vector_req;
    logic       rd_wr;
    logic [1:0] snoop_ctrl;
    logic       bus_granted_in;
    logic       bus_owned_line;
    logic       cache_off_in;
    logic [2:0] irq_level_n;
  } bsac_pins_t;

  typedef struct packed {
    bsac_arb_t  arb;
    bsac_snp_t  snp;
    logic       in_reset;
    logic       xfer_busy;
    logic       xfer_start;
    logic       bus_want;
    logic       mem_hold_off;
    logic       ack_drv;
    logic       ack_oe;
    logic       snp_write;
    logic [1:0] snp_op;
    logic       bus_mode_normal;
    logic [2:0] drive_large;
    logic       cache_on;
    logic       ext_reset;
    logic [2:0] irq_level;
    logic       irq_waiting;
    logic       acc_taken;
    logic       acc_done;
    logic       acc_err;
    logic       autovec;
    logic       snoop_lookup;
    logic       snoop_update;
    logic       snoop_inval;
  } bsac_state_t;

endpackage : bsac_pkg

// ==== core/bsac_sync.sv ====
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module bsac_sync #(
  parameter int WIDTH = 1
) (
  input  wire  logic             mclk,
  input  wire  logic             rst_n,
  input  wire  logic [WIDTH-1:0] d,
  output logic       [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } bsac_sync_t;

  bsac_sync_t sync_reg;
  bsac_sync_t sync_next;

  // first stage is read only by the second
  always_comb begin
    sync_next        = sync_reg;
    sync_next.meta   = d;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.stable;
endmodule : bsac_sync

// ==== core/bsac_ctrl.sv ====
// bus snoop, arbitration, reset and interrupt pin control
`timescale 1ns/1ps
`include "bsac_cfg.svh"

// Notes on behaviour
// - snoop control inputs are ignored while this device owns the bus
// - snooped read may be served from cache; snooped write updates or invalidates
// - mem_hold_off stays asserted throughout reset
// - on snoop, hold memory off until decided; release if no intervention
// - on intervention keep memory held off and finish the transfer as slave
// - mem_hold_off is negated whenever this device is bus master
// - xfer_ack and xfer_err_ack are ignored while mem_hold_off is asserted in snoop
// - bus_want on need; dropped when last pending access starts
// - bus_want may be withdrawn without a transfer; arbiter tolerates it
// - grant means the bus is ours once the current access completes
// - take bus only with grant asserted and bus_owned_line sampled negated
// - keep bus_owned_line until grant removed and transfer done
// - on release drive bus_owned_line negated, then stop driving it
// - cache_off_in disables caches at next boundary; snooping unaffected
// - cache_off_in level in reset selects normal (high) or multiplexed (low) mode
// - hard_reset_in is synchronised to the clock before reset begins
// - in reset all driven pins float and outputs negate except mem_hold_off, irq_level, cache_enable, snoop_write and the mode straps
// - ext_reset_out asserts while the reset instruction executes
// - irq_level_n is active low, top line most significant
// - irq_level_n lines in reset pick drive strength: high small, low large
// - irq_waiting when recognised level exceeds the status_reg mask
// - auto_vector_req with xfer_ack in interrupt acknowledge asks for autovector
// - when intervening, this device drives xfer_ack for each data beat
// - xfer_start is one clock per transfer; watched to detect snooped transfers
module bsac_ctrl (
  input  wire  logic                mclk,
  input  wire  logic                rst_n,
  input  wire  bsac_pkg::bsac_pins_t pins,
  input  wire  logic                acc_pending,
  input  wire  logic                acc_more,
  input  wire  logic                iack_cycle,
  input  wire  logic                reset_instr,
  input  wire  logic [2:0]          status_reg_mask,
  input  wire  logic                cache_boundary,
  input  wire  logic                snoop_decided,
  input  wire  logic                snoop_intervene,
  input  wire  logic                cache_beat,
  input  wire  logic                cache_last,
  output logic                      mem_hold_off,
  output logic                      bus_want,
  output logic                      bus_owned_out,
  output logic                      bus_owned_oe,
  output logic                      xfer_start_out,
  output logic                      xfer_start_oe,
  output logic                      xfer_ack_out,
  output logic                      xfer_ack_oe,
  output logic                      ext_reset_out,
  output logic                      irq_waiting,
  output logic [2:0]                irq_level,
  output logic                      cache_enable,
  output logic                      bus_mode_normal,
  output logic [2:0]                drive_large,
  output logic                      acc_taken,
  output logic                      acc_done,
  output logic                      acc_err,
  output logic                      autovec_hit,
  output logic                      snoop_lookup,
  output logic                      snoop_write,
  output logic                      snoop_update,
  output logic                      snoop_inval
);
  import bsac_pkg::*;

  // idle levels of the pins; the synchroniser clears to zero, so these bits travel inverted
  localparam bsac_pins_t pin_idle = '{irq_level_n: 3'h7, default: '0};

  bsac_pins_t  pin_x;
  bsac_pins_t  pin_s;
  bsac_state_t s_reg;
  bsac_state_t s_next;
  logic        master;
  logic        snoop_on;

  bsac_sync #(
    .WIDTH ($bits(bsac_pins_t))
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (pins ^ pin_idle),
    .q     (pin_x)
  );
  // no false interrupt level straight after rst_n
  assign pin_s = pin_x ^ pin_idle;

  assign master   = (s_reg.arb == ARB_OWN) || (s_reg.arb == ARB_REL);
  assign snoop_on = (pin_s.snoop_ctrl == `BSAC_SNP_UPDATE) ||
                    (pin_s.snoop_ctrl == `BSAC_SNP_INVAL);

  always_comb begin
    s_next              = s_reg;
    s_next.xfer_start   = 1'b0;
    s_next.acc_taken    = 1'b0;
    s_next.acc_done     = 1'b0;
    s_next.acc_err      = 1'b0;
    s_next.autovec      = 1'b0;
    s_next.ack_drv      = 1'b0;
    s_next.snoop_lookup = 1'b0;
    s_next.snoop_update = 1'b0;
    s_next.snoop_inval  = 1'b0;
    s_next.ext_reset    = reset_instr;
    s_next.irq_level    = ~pin_s.irq_level_n;
    s_next.irq_waiting  = s_next.irq_level > status_reg_mask;
    if (cache_boundary) begin
      s_next.cache_on = ~pin_s.cache_off_in;
    end

    case (s_reg.arb)
      ARB_IDLE: begin
        s_next.bus_want = acc_pending;
        if (acc_pending) begin
          s_next.arb = ARB_REQ;
        end
      end
      ARB_REQ: begin
        s_next.bus_want = acc_pending;
        if (!acc_pending) begin
          s_next.arb = ARB_IDLE;
        end else if (pin_s.bus_granted_in && !pin_s.bus_owned_line) begin
          s_next.arb = ARB_OWN;
        end
      end
      ARB_OWN: begin
        if (!s_reg.xfer_busy && acc_pending && pin_s.bus_granted_in) begin
          s_next.xfer_busy  = 1'b1;
          s_next.xfer_start = 1'b1;
          s_next.acc_taken  = 1'b1;
          s_next.bus_want   = acc_more;
        end else if (!s_reg.xfer_busy && acc_pending) begin
          s_next.bus_want = 1'b1;
        end
        if (s_reg.xfer_busy && (pin_s.xfer_ack || pin_s.xfer_err_ack)) begin
          s_next.xfer_busy = 1'b0;
          s_next.acc_done  = 1'b1;
          s_next.acc_err   = pin_s.xfer_err_ack;
          s_next.autovec   = iack_cycle && pin_s.xfer_ack && pin_s.auto_vector_req;
        end
        if (!pin_s.bus_granted_in && !s_reg.xfer_busy) begin
          s_next.arb = ARB_REL;
        end
      end
      ARB_REL: begin
        s_next.arb      = ARB_IDLE;
        s_next.bus_want = acc_pending;
      end
      default: begin
        s_next.arb = ARB_IDLE;
      end
    endcase

    case (s_reg.snp)
      SNP_IDLE: begin
        if (!master && pin_s.xfer_start && snoop_on) begin
          s_next.snp          = SNP_LOOK;
          s_next.snp_write    = ~pin_s.rd_wr;
          s_next.snp_op       = pin_s.snoop_ctrl;
          s_next.snoop_lookup = 1'b1;
        end
      end
      SNP_LOOK: begin
        if (snoop_decided) begin
          s_next.snp = snoop_intervene ? SNP_INTV : SNP_MEM;
        end
      end
      SNP_MEM: begin
        if (pin_s.xfer_ack || pin_s.xfer_err_ack) begin
          s_next.snp = SNP_IDLE;
          if (s_reg.snp_write && !pin_s.xfer_err_ack) begin
            s_next.snoop_update = s_reg.snp_op == `BSAC_SNP_UPDATE;
            s_next.snoop_inval  = s_reg.snp_op == `BSAC_SNP_INVAL;
          end
        end
      end
      SNP_INTV: begin
        if (cache_beat) begin
          s_next.ack_drv = 1'b1;
          if (cache_last) begin
            s_next.snp = SNP_IDLE;
            s_next.snoop_update = s_reg.snp_write;
          end
        end
      end
      default: begin
        s_next.snp = SNP_IDLE;
      end
    endcase

    s_next.ack_oe       = (s_next.snp == SNP_INTV) || s_next.ack_drv;
    s_next.mem_hold_off = (s_next.snp == SNP_LOOK) || (s_next.snp == SNP_INTV);

    s_next.in_reset = pin_s.hard_reset_in;
    if (pin_s.hard_reset_in) begin
      s_next.arb          = ARB_IDLE;
      s_next.snp          = SNP_IDLE;
      s_next.xfer_busy    = 1'b0;
      s_next.xfer_start   = 1'b0;
      s_next.bus_want     = 1'b0;
      s_next.ack_drv      = 1'b0;
      s_next.ack_oe       = 1'b0;
      s_next.ext_reset    = 1'b0;
      s_next.irq_waiting  = 1'b0;
      s_next.acc_taken    = 1'b0;
      s_next.acc_done     = 1'b0;
      s_next.acc_err      = 1'b0;
      s_next.autovec      = 1'b0;
      s_next.snoop_lookup = 1'b0;
      s_next.snoop_update = 1'b0;
      s_next.snoop_inval  = 1'b0;
      s_next.mem_hold_off = 1'b1;
      s_next.bus_mode_normal = pin_s.cache_off_in;
      s_next.drive_large = pin_s.irq_level_n ^ 3'h7;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg                 <= '0;
      s_reg.arb             <= ARB_IDLE;
      s_reg.snp             <= SNP_IDLE;
      s_reg.in_reset        <= 1'b1;
      s_reg.mem_hold_off    <= `BSAC_RST_HOLD_OFF;
      s_reg.bus_mode_normal <= `BSAC_RST_BUS_MODE;
      s_reg.drive_large     <= `BSAC_RST_DRIVE;
      s_reg.cache_on        <= `BSAC_RST_CACHE_ON;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mem_hold_off    = s_reg.mem_hold_off && !master;
  assign bus_want        = s_reg.bus_want;
  assign bus_owned_out   = s_reg.arb == ARB_OWN;
  assign bus_owned_oe    = master;
  assign xfer_start_out  = s_reg.xfer_start;
  assign xfer_start_oe   = s_reg.arb == ARB_OWN;
  assign xfer_ack_out    = s_reg.ack_drv;
  assign xfer_ack_oe     = s_reg.ack_oe;
  assign ext_reset_out   = s_reg.ext_reset;
  assign irq_waiting     = s_reg.irq_waiting;
  assign irq_level       = s_reg.irq_level;
  assign cache_enable    = s_reg.cache_on;
  assign bus_mode_normal = s_reg.bus_mode_normal;
  assign drive_large     = s_reg.drive_large;
  assign acc_taken       = s_reg.acc_taken;
  assign acc_done        = s_reg.acc_done;
  assign acc_err         = s_reg.acc_err;
  assign autovec_hit     = s_reg.autovec;
  assign snoop_lookup    = s_reg.snoop_lookup;
  assign snoop_write     = s_reg.snp_write;
  assign snoop_update    = s_reg.snoop_update;
  assign snoop_inval     = s_reg.snoop_inval;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  hold_in_reset_a: assert property (
    pin_s.hard_reset_in |=> mem_hold_off)
    else $error("mem_hold_off not asserted in reset");
  master_no_hold_a: assert property (
    bus_owned_oe |-> !mem_hold_off)
    else $error("mem_hold_off asserted while master");
  snoop_ignored_a: assert property (
    (s_reg.arb == ARB_OWN && s_reg.snp == SNP_IDLE) |=> !snoop_lookup)
    else $error("snoop started while master");
  take_free_bus_a: assert property (
    $rose(bus_owned_oe) |-> $past(pin_s.bus_granted_in) && !$past(pin_s.bus_owned_line))
    else $error("bus taken without grant or while busy");
  keep_bus_a: assert property (
    (s_reg.arb == ARB_OWN && (s_reg.xfer_busy || pin_s.bus_granted_in)
     && !pin_s.hard_reset_in) |=> bus_owned_out)
    else $error("bus released early");
  release_order_a: assert property (
    ($fell(bus_owned_out) && !s_reg.in_reset && !pin_s.hard_reset_in)
    |-> bus_owned_oe ##1 !bus_owned_oe)
    else $error("bus_owned_line release order wrong");
  start_one_clock_a: assert property (
    xfer_start_out |=> !xfer_start_out)
    else $error("xfer_start longer than one clock");
  ack_ignored_a: assert property (
    (s_reg.snp == SNP_LOOK && pin_s.xfer_ack && !snoop_decided && !pin_s.hard_reset_in)
    |=> s_reg.snp == SNP_LOOK && mem_hold_off)
    else $error("ack seen while memory held off");
  want_drop_a: assert property (
    acc_taken |-> bus_want == $past(acc_more))
    else $error("bus_want wrong at transfer start");
  intv_ack_a: assert property (
    (s_reg.snp == SNP_INTV && cache_beat && !pin_s.hard_reset_in)
    |=> xfer_ack_out && xfer_ack_oe)
    else $error("intervention beat not acknowledged");
  irq_pending_a: assert property (
    ((~pin_s.irq_level_n) > status_reg_mask && !pin_s.hard_reset_in) |=> irq_waiting)
    else $error("irq_waiting missing");
  strap_mode_a: assert property (
    pin_s.hard_reset_in |=> bus_mode_normal == $past(pin_s.cache_off_in))
    else $error("bus mode strap not captured");
  reset_quiet_a: assert property (
    s_reg.in_reset |-> !bus_want && !bus_owned_oe && !xfer_ack_oe && !ext_reset_out)
    else $error("output active during reset");
endmodule : bsac_ctrl

// ==== tb/bsac_far_model.sv ====
// far side model: arbiter, bus-owned wire and memory responder
`timescale 1ns/1ps
module bsac_far_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       bus_want,
  input  wire logic       bus_owned_out,
  input  wire logic       bus_owned_oe,
  input  wire logic       xfer_start_out,
  input  wire logic       xfer_ack_out,
  input  wire logic       xfer_ack_oe,
  input  wire logic       alt_hold,
  input  wire logic [3:0] ack_wait,
  input  wire logic       err_sel,
  input  wire logic       alt_ack,
  output logic            bus_granted_in,
  output logic            bus_owned_line,
  output logic            xfer_ack,
  output logic            xfer_err_ack
);
  logic [4:0] cnt_reg;
  logic       mem_ack;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_granted_in <= 1'h0;
    end else begin
      bus_granted_in <= bus_want & ~alt_hold;
    end
  end
  // ack_wait lets the memory answer promptly or slowly
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
    end else if (xfer_start_out) begin
      cnt_reg <= {1'h0, ack_wait} + 5'h01;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
  assign mem_ack = (cnt_reg == 5'h01);
  assign bus_owned_line = bus_owned_oe ? bus_owned_out : alt_hold;
  assign xfer_ack = xfer_ack_oe ? xfer_ack_out : (mem_ack | alt_ack);
  assign xfer_err_ack = mem_ack & err_sel;
endmodule : bsac_far_model

// ==== tb/tb.sv ====
// self-checking bench for the bus snoop and arbitration control block
`timescale 1ns/1ps
module tb;
  import bsac_pkg::*;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic hr, ts, av, rdwr, cd, acc_pending, acc_more, iack_cycle, reset_instr;
  logic cache_boundary, snoop_decided, snoop_intervene, cache_beat, cache_last;
  logic alt_hold, err_sel, alt_ack, rel_phase;
  logic [1:0] sc;
  logic [2:0] ipl, status_reg_mask, irq_level, drive_large;
  logic [3:0] ack_wait;
  logic mem_hold_off, bus_want, bus_owned_out, bus_owned_oe, xfer_start_out;
  logic xfer_start_oe, xfer_ack_out, xfer_ack_oe, ext_reset_out, irq_waiting;
  logic cache_enable, bus_mode_normal, acc_taken, acc_done, acc_err, autovec_hit;
  logic snoop_lookup, snoop_write, snoop_update, snoop_inval;
  wire  bus_granted_in, bus_owned_line, xfer_ack, xfer_err_ack;
  bsac_pins_t pins;
  int   miscompares = 0;
  int   checked = 0;
  int   n_lk = 0, n_up = 0, n_inv = 0, n_ack = 0, n_tk = 0;

  always #5 mclk = ~mclk;
  // the design's own start pulse is seen on the shared wire
  assign pins = {hr, xfer_start_oe ? xfer_start_out : ts, xfer_ack, xfer_err_ack, av, rdwr,
                 sc, bus_granted_in, bus_owned_line, cd, ipl};
  always_comb rel_phase = bus_owned_oe & ~bus_owned_out;
  always @(posedge mclk) begin
    n_lk  += snoop_lookup;
    n_up  += snoop_update;
    n_inv += snoop_inval;
    n_ack += xfer_ack_out & xfer_ack_oe;
    n_tk  += acc_taken;
  end

  bsac_ctrl bsac_ctrl_inst (.mclk, .rst_n, .pins, .acc_pending, .acc_more, .iack_cycle,
    .reset_instr, .status_reg_mask, .cache_boundary, .snoop_decided, .snoop_intervene,
    .cache_beat, .cache_last, .mem_hold_off, .bus_want, .bus_owned_out, .bus_owned_oe,
    .xfer_start_out, .xfer_start_oe, .xfer_ack_out, .xfer_ack_oe, .ext_reset_out,
    .irq_waiting, .irq_level, .cache_enable, .bus_mode_normal, .drive_large, .acc_taken,
    .acc_done, .acc_err, .autovec_hit, .snoop_lookup, .snoop_write, .snoop_update,
    .snoop_inval);
  bsac_far_model bsac_far_model_inst (.mclk, .rst_n, .bus_want, .bus_owned_out,
    .bus_owned_oe, .xfer_start_out, .xfer_ack_out, .xfer_ack_oe, .alt_hold, .ack_wait,
    .err_sel, .alt_ack, .bus_granted_in, .bus_owned_line, .xfer_ack, .xfer_err_ack);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // sample 1ns after the edge so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wait_hi(ref logic s, input int lim);
    int i;
    for (i = 0; i < lim && s !== 1'h1; i++) tick(1);
    chk(s, 1'h1);
  endtask : wait_hi

  task automatic t_reset;
    chk(mem_hold_off, 1'h1);
    chk({bus_want, bus_owned_oe, xfer_ack_oe, ext_reset_out}, 4'h0);
    @(posedge mclk) rst_n <= 1'h1;
    @(posedge mclk) {hr, cd, ipl} <= {1'h1, 1'h0, 3'h5};
    tick(5);
    chk(mem_hold_off, 1'h1);
    chk({irq_waiting, bus_owned_oe, xfer_start_oe}, 3'h0);
    @(posedge mclk) hr <= 1'h0;
    tick(6);
    chk(bus_mode_normal, 1'h0);
    chk(drive_large, 3'h2);
    @(posedge mclk) {cd, ipl} <= {1'h1, 3'h7};
    tick(4);
  endtask : t_reset

  task automatic t_access(input logic iack, input logic avr, input logic err,
                          input logic [3:0] dly);
    int l0;
    l0 = n_lk;
    @(posedge mclk) {acc_pending, iack_cycle, av, err_sel, sc} <= {1'h1, iack, avr, err, 2'h1};
    ack_wait <= dly;
    wait_hi(bus_want, 10);
    wait_hi(bus_owned_oe, 20);
    chk({bus_granted_in, bus_owned_out}, 2'h3);
    chk(mem_hold_off, 1'h0);
    wait_hi(acc_taken, 10);
    chk(xfer_start_out, 1'h1);
    @(posedge mclk) acc_pending <= 1'h0;
    #1 chk(bus_want, 1'h0);
    wait_hi(acc_done, 30);
    chk({acc_err, autovec_hit}, {err, iack & avr});
    wait_hi(rel_phase, 20);
    tick(1);
    chk(bus_owned_oe, 1'h0);
    chk(n_lk - l0, 0);
    @(posedge mclk) sc <= 2'h0;
  endtask : t_access

  task automatic t_withdraw;
    int k0;
    k0 = n_tk;
    @(posedge mclk) {alt_hold, acc_pending} <= 2'h3;
    wait_hi(bus_want, 10);
    tick(4);
    @(posedge mclk) acc_pending <= 1'h0;
    tick(4);
    chk({bus_want, bus_owned_oe}, 2'h0);
    chk(n_tk - k0, 0);
    @(posedge mclk) alt_hold <= 1'h0;
  endtask : t_withdraw

  task automatic t_snoop(input logic [1:0] op, input logic rd, input logic intv);
    int l0, u0, i0, a0;
    {l0, u0, i0, a0} = {n_lk, n_up, n_inv, n_ack};
    @(posedge mclk) {sc, rdwr, ts} <= {op, rd, 1'h1};
    @(posedge mclk) ts <= 1'h0;
    if (op == 2'h0 || op == 2'h3) begin
      tick(8);
      chk(n_lk - l0, 0);
      return;
    end
    wait_hi(snoop_lookup, 6);
    chk({mem_hold_off, snoop_write}, {1'h1, ~rd});
    @(posedge mclk) alt_ack <= 1'h1;
    @(posedge mclk) alt_ack <= 1'h0;
    tick(5);
    chk(n_up - u0 + n_inv - i0, 0);
    @(posedge mclk) {snoop_decided, snoop_intervene} <= {1'h1, intv};
    @(posedge mclk) snoop_decided <= 1'h0;
    tick(2);
    chk(mem_hold_off, intv);
    if (!intv) begin
      @(posedge mclk) alt_ack <= 1'h1;
      @(posedge mclk) alt_ack <= 1'h0;
      tick(6);
      chk(n_up - u0, op == 2'h1 && !rd);
      chk(n_inv - i0, op == 2'h2 && !rd);
    end else begin
      chk(xfer_ack_oe, 1'h1);
      @(posedge mclk) cache_beat <= 1'h1;
      @(posedge mclk) cache_last <= 1'h1;
      @(posedge mclk) {cache_beat, cache_last} <= 2'h0;
      tick(4);
      chk(n_ack - a0, 2);
      chk(mem_hold_off, 1'h0);
    end
    @(posedge mclk) sc <= 2'h0;
  endtask : t_snoop

  task automatic t_cache;
    @(posedge mclk) cd <= 1'h1;
    tick(4);
    chk(cache_enable, 1'h1);
    @(posedge mclk) cache_boundary <= 1'h1;
    @(posedge mclk) cache_boundary <= 1'h0;
    tick(1);
    chk(cache_enable, 1'h0);
    // snooping must carry on with caches off
    t_snoop(2'h2, 1'h0, 1'h0);
    @(posedge mclk) cd <= 1'h0;
    tick(4);
    @(posedge mclk) cache_boundary <= 1'h1;
    @(posedge mclk) cache_boundary <= 1'h0;
    tick(1);
    chk(cache_enable, 1'h1);
  endtask : t_cache

  task automatic t_irq;
    logic [9:0] tbl [5] = '{{3'h5, 3'h1, 1'h1, 3'h2}, {3'h5, 3'h2, 1'h0, 3'h2},
                             {3'h0, 3'h6, 1'h1, 3'h7}, {3'h7, 3'h0, 1'h0, 3'h0},
                             {3'h3, 3'h3, 1'h1, 3'h4}};
    foreach (tbl[i]) begin
      @(posedge mclk) {ipl, status_reg_mask} <= tbl[i][9:4];
      tick(5);
      chk({irq_waiting, irq_level}, tbl[i][3:0]);
    end
  endtask : t_irq

  task automatic t_ext_reset;
    @(posedge mclk) reset_instr <= 1'h1;
    tick(3);
    chk(ext_reset_out, 1'h1);
    @(posedge mclk) reset_instr <= 1'h0;
    tick(3);
    chk(ext_reset_out, 1'h0);
  endtask : t_ext_reset

  task automatic give_verdict;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {hr, ts, av, rdwr, acc_pending, acc_more, iack_cycle, reset_instr, cache_boundary} = '0;
    {snoop_decided, snoop_intervene, cache_beat, cache_last, alt_hold, err_sel} = '0;
    {alt_ack, sc, status_reg_mask, ack_wait} = '0;
    cd = 1'h1;
    ipl = 3'h7;
    tick(4);
    t_reset;
    t_access(1'h0, 1'h0, 1'h0, 4'h0);
    t_access(1'h1, 1'h1, 1'h1, 4'h5);
    t_access(1'h0, 1'h1, 1'h0, 4'h2);
    t_withdraw;
    for (int op = 0; op < 4; op++) t_snoop(op[1:0], 1'h0, 1'h0);
    t_snoop(2'h1, 1'h1, 1'h0);
    t_snoop(2'h1, 1'h1, 1'h1);
    t_cache;
    t_irq;
    t_ext_reset;
    give_verdict;
  end

  // whole run needs well under 1000 cycles; allow twenty times that
  initial begin
    #200000;
    miscompares++;
    give_verdict;
  end
endmodule : tb
